/* File: rtl/ebm_pkg.sv */
// Package: constants and types for the emulation bus mapper and trace feed
package ebm_pkg;
    localparam int ADDR_W      = 24;
    localparam int DATA_W      = 16;
    localparam int STAT_W      = 8;
    localparam int BLK_W       = 6;
    localparam int BLK_LSB     = 18;
    localparam int ATTR_W      = 3;
    localparam int ATTR_EMUL   = 2;
    localparam int ATTR_KIND_HI = 1;
    localparam int ATTR_KIND_LO = 0;
    localparam logic [1:0] KIND_RAM     = 2'h0;
    localparam logic [1:0] KIND_ROM     = 2'h1;
    localparam logic [1:0] KIND_GUARDED = 2'h2;
    localparam logic [ATTR_W-1:0] ATTR_RESET = 3'h2;
    localparam int STAT_FETCH  = 0;
    localparam int STAT_WRITE  = 1;
    localparam int FIFO_DEPTH  = 4;
    localparam int PTR_W       = 2;
    localparam int STALL_TIME_NS = 500;
    localparam int CLOCK_NS    = 50;
    localparam int STALL_CYCLES = STALL_TIME_NS / CLOCK_NS;
    localparam logic [3:0] STALL_CNT = 4'(STALL_CYCLES);

    typedef enum logic [1:0]
    {
        BUS_IDLE = 2'b00,
        BUS_ADDR = 2'b01,
        BUS_DATA = 2'b10
    } ebm_bus_state_type;

    // Fetch kind test used by the trace feed push and analysis clock
    function automatic logic is_fetch(input logic [STAT_W-1:0] st);
        return st[STAT_FETCH];
    endfunction
endpackage

/* File: rtl/ebm_map_if.sv */
// Interface: mapper table lookup and load path
`timescale 1ns/100ps
`default_nettype none
interface ebm_map_if;
    logic [ebm_pkg::BLK_W-1:0]  rd_blk;
    logic [ebm_pkg::ATTR_W-1:0] rd_attr;
    logic                       wr_en;
    logic [ebm_pkg::BLK_W-1:0]  wr_blk;
    logic [ebm_pkg::ATTR_W-1:0] wr_attr;
    modport host (output rd_blk, output wr_en, output wr_blk, output wr_attr, input rd_attr);
    modport mem  (input rd_blk, input wr_en, input wr_blk, input wr_attr, output rd_attr);
endinterface
`default_nettype wire

/* File: rtl/ebm_map_mem.sv */
// Mapper lookup memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module ebm_map_mem
#(
    parameter int BLOCKS = 64
)
(
    // Clock and reset
    input wire logic     clk,
    input wire logic     rst,
    // Table port
    ebm_map_if.mem       map
);
    logic [ebm_pkg::ATTR_W-1:0] table_reg [BLOCKS];

    // ------------------------------------------------------------
    // Table storage
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < BLOCKS; i++)
                table_reg[i] <= ebm_pkg::ATTR_RESET;
        end
        else if (map.wr_en)
        begin
            table_reg[map.wr_blk] <= map.wr_attr;
        end
    end

    // ------------------------------------------------------------
    // Registered read
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            map.rd_attr <= ebm_pkg::ATTR_RESET;
        else
            map.rd_attr <= table_reg[map.rd_blk];
    end
endmodule
`default_nettype wire

/* File: rtl/ebm_fetch_queue.sv */
// Queue of fetched bus words held until execution
`timescale 1ns/100ps
`default_nettype none
module ebm_fetch_queue
#(
    parameter int WIDTH = 48,
    parameter int DEPTH = 4,
    parameter int PW    = 2
)
(
    // Clock and reset
    input wire logic             clk,
    input wire logic             rst,
    // Push side
    input wire logic             push,
    input wire logic [WIDTH-1:0] push_data,
    // Pop side
    input wire logic             pop,
    output logic [WIDTH-1:0]     pop_data,
    output logic                 not_empty,
    // Flush on break
    input wire logic             flush
);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW:0]      count_reg;
    logic             do_push;
    logic             do_pop;

    assign do_pop  = pop && (count_reg != '0);
    assign do_push = push && ((count_reg != (PW+1)'(DEPTH)) || do_pop);
    assign not_empty = (count_reg != '0);
    assign pop_data  = mem_reg[rd_ptr_reg];

    // ------------------------------------------------------------
    // Storage and pointers; oldest overwritten never, newest dropped when full with no pop in the same cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            for (int i = 0; i < DEPTH; i++)
                mem_reg[i] <= '0;
        end
        else if (flush)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (do_push)
            begin
                mem_reg[wr_ptr_reg] <= push_data;
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            count_reg <= count_reg + (PW+1)'(do_push) - (PW+1)'(do_pop);
        end
    end
endmodule
`default_nettype wire

/* File: rtl/ebm_top.sv */
// Emulation bus mapper, buffer steering, break and trace feed
//
// Contract
// - Bus-cycle mode: one analysis clock per bus cycle with its own fields.
// - Execution mode: clock non-fetch cycles and each executed fetched instruction; one executed as a non-fetch cycle ends is popped but not clocked.
// - Execution clocks use held fetch fields, released only on execution.
// - Trace mode input switches between the two modes at any time.
// - Address latched in address phase and given to the mapper.
// - Non-DMA emulation cycles route data through buffers to emulation memory.
// - Each cycle goes to target resources or emulation memory.
// - Target buffer enable follows the mapper decision in non-DMA cycles and stays off in DMA cycles; direction follows the latched RW.
// - Table gives per block RAM, ROM or guarded plus emulation flag.
// - Guarded block access raises a monitor break request.
// - With option set, ROM writes raise a monitor break request.
// - Target-access output low for target cycles, high for emulation.
// - DMA access to emulation memory returns ready on the ack lead.
// - Configuration accepted only while the processor is held in reset.
// - While running, status is shown and host stall requests accepted.
// - Break request diverts processor into monitor code.
`timescale 1ns/100ps
`default_nettype none
module ebm_top
#(
    parameter int BLOCKS = 64
)
(
    // Clock and reset
    input wire logic                          CLOCK,
    input wire logic                          RST,
    // Processor bus
    input wire logic                          AS_N,
    input wire logic                          RW,
    input wire logic                          DMA_CYCLE,
    input wire logic                          EXEC_STROBE,
    input wire logic [ebm_pkg::ADDR_W-1:0]    BUS_ADDR,
    input wire logic [ebm_pkg::DATA_W-1:0]    BUS_DATA,
    input wire logic [ebm_pkg::STAT_W-1:0]    BUS_STAT,
    // Emulation memory
    input wire logic                          EMEM_READY,
    output logic [ebm_pkg::ADDR_W-1:0]        EMEM_ADDR,
    output logic                              EMEM_SEL,
    output logic                              EMEM_BUF_EN,
    output logic                              EMEM_BUF_DIR,
    // Target interface
    output logic                              USER_MEM_N,
    output logic                              TGT_BUF_EN,
    output logic                              TGT_BUF_DIR,
    output logic                              DMA_READY_ACK,
    output logic                              DMA_READY_ACK_OE,
    // Break control
    input wire logic                          ROM_WR_BREAK_EN,
    output logic                              BREAK_REQ,
    output logic                              IN_MONITOR,
    input wire logic                          MONITOR_EXIT,
    // Host configuration and status
    input wire logic                          CPU_RESET_HELD,
    input wire logic                          CFG_WR,
    input wire logic [ebm_pkg::BLK_W-1:0]     CFG_BLK,
    input wire logic [ebm_pkg::ATTR_W-1:0]    CFG_ATTR,
    output logic                              CFG_ACCEPT,
    input wire logic                          HOST_STALL_REQ,
    output logic                              CPU_HALT,
    output logic [3:0]                        POD_STATUS,
    // Analysis bus
    input wire logic                          TRACE_EXEC_MODE,
    output logic                              ANA_CLK,
    output logic [ebm_pkg::ADDR_W-1:0]        ANA_ADDR,
    output logic [ebm_pkg::DATA_W-1:0]        ANA_DATA,
    output logic [ebm_pkg::STAT_W-1:0]        ANA_STAT
);
    localparam int TW = ebm_pkg::ADDR_W + ebm_pkg::DATA_W + ebm_pkg::STAT_W;

    ebm_map_if map ();

    ebm_pkg::ebm_bus_state_type    state_reg;
    logic [ebm_pkg::ADDR_W-1:0]    addr_reg;
    logic [ebm_pkg::STAT_W-1:0]    stat_reg;
    logic                          rw_reg;
    logic                          dma_reg;
    logic                          attr_valid_reg;
    logic                          emul_sel;
    logic [1:0]                    kind;
    logic                          data_phase;
    logic                          cycle_end;
    logic [3:0]                    stall_cnt_reg;
    logic [TW-1:0]                 fq_out;
    logic                          fq_valid;
    logic                          fq_push;
    logic                          fq_pop;
    logic                          cfg_ok;

    // ------------------------------------------------------------
    // Bus cycle phases and address latch
    // ------------------------------------------------------------
    assign data_phase = (state_reg == ebm_pkg::BUS_DATA);
    assign cycle_end  = data_phase && AS_N;

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            state_reg <= ebm_pkg::BUS_IDLE;
        else
        begin
            case (state_reg)
                ebm_pkg::BUS_IDLE: if (!AS_N) state_reg <= ebm_pkg::BUS_ADDR;
                ebm_pkg::BUS_ADDR: state_reg <= AS_N ? ebm_pkg::BUS_IDLE : ebm_pkg::BUS_DATA;
                ebm_pkg::BUS_DATA: if (AS_N) state_reg <= ebm_pkg::BUS_IDLE;
                default:           state_reg <= ebm_pkg::BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            addr_reg <= '0;
            stat_reg <= '0;
            rw_reg   <= 1'b1;
            dma_reg  <= 1'b0;
        end
        else if (state_reg == ebm_pkg::BUS_IDLE && !AS_N)
        begin
            addr_reg <= BUS_ADDR;
            stat_reg <= BUS_STAT;
            rw_reg   <= RW;
            dma_reg  <= DMA_CYCLE;
        end
    end

    // ------------------------------------------------------------
    // Mapper lookup; result ready in the address phase
    // ------------------------------------------------------------
    assign cfg_ok      = CPU_RESET_HELD && CFG_WR;
    assign map.rd_blk  = (state_reg == ebm_pkg::BUS_IDLE)
                       ? BUS_ADDR[ebm_pkg::BLK_LSB +: ebm_pkg::BLK_W]
                       : addr_reg[ebm_pkg::BLK_LSB +: ebm_pkg::BLK_W];
    assign map.wr_en   = cfg_ok;
    assign map.wr_blk  = CFG_BLK;
    assign map.wr_attr = CFG_ATTR;

    ebm_map_mem #(.BLOCKS(BLOCKS)) u_map
    (
        .clk (CLOCK),
        .rst (RST),
        .map (map)
    );

    assign emul_sel = map.rd_attr[ebm_pkg::ATTR_EMUL];
    assign kind     = map.rd_attr[ebm_pkg::ATTR_KIND_HI:ebm_pkg::ATTR_KIND_LO];

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            attr_valid_reg <= 1'b0;
        else
            attr_valid_reg <= (state_reg != ebm_pkg::BUS_IDLE) && !AS_N;
    end

    // ------------------------------------------------------------
    // Buffer steering and target-access output
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            USER_MEM_N   <= 1'b0;
            TGT_BUF_EN   <= 1'b0;
            TGT_BUF_DIR  <= 1'b0;
            EMEM_BUF_EN  <= 1'b0;
            EMEM_BUF_DIR <= 1'b0;
            EMEM_SEL     <= 1'b0;
            EMEM_ADDR    <= '0;
        end
        else
        begin
            USER_MEM_N   <= attr_valid_reg ? emul_sel : 1'b0;
            EMEM_SEL     <= attr_valid_reg && emul_sel;
            EMEM_ADDR    <= addr_reg;
            EMEM_BUF_EN  <= attr_valid_reg && emul_sel && !dma_reg;
            EMEM_BUF_DIR <= rw_reg;
            TGT_BUF_EN   <= attr_valid_reg && !emul_sel && !dma_reg;
            TGT_BUF_DIR  <= rw_reg;
        end
    end

    // ------------------------------------------------------------
    // DMA ready acknowledge lead
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            DMA_READY_ACK    <= 1'b1;
            DMA_READY_ACK_OE <= 1'b0;
        end
        else
        begin
            DMA_READY_ACK_OE <= attr_valid_reg && emul_sel && dma_reg;
            DMA_READY_ACK    <= !EMEM_READY;
        end
    end

    // ------------------------------------------------------------
    // Break request and monitor entry
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            BREAK_REQ  <= 1'b0;
            IN_MONITOR <= 1'b0;
        end
        else
        begin
            BREAK_REQ <= attr_valid_reg && !IN_MONITOR && !BREAK_REQ
                      && ((kind == ebm_pkg::KIND_GUARDED)
                       || (ROM_WR_BREAK_EN && kind == ebm_pkg::KIND_ROM && !rw_reg));
            if (BREAK_REQ)
                IN_MONITOR <= 1'b1;
            else if (MONITOR_EXIT)
                IN_MONITOR <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Configuration, host stall and status
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            CFG_ACCEPT <= 1'b0;
        else
            CFG_ACCEPT <= cfg_ok;
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            stall_cnt_reg <= '0;
            CPU_HALT      <= 1'b0;
        end
        else
        begin
            if (HOST_STALL_REQ && !CPU_RESET_HELD && stall_cnt_reg == '0)
                stall_cnt_reg <= ebm_pkg::STALL_CNT;
            else if (stall_cnt_reg != '0)
                stall_cnt_reg <= stall_cnt_reg - 1'b1;
            CPU_HALT <= (stall_cnt_reg != '0);
        end
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            POD_STATUS <= '0;
        else
            POD_STATUS <= {CPU_RESET_HELD, IN_MONITOR, CPU_HALT, TRACE_EXEC_MODE};
    end

    // ------------------------------------------------------------
    // Trace feed
    // ------------------------------------------------------------
    assign fq_push = cycle_end && TRACE_EXEC_MODE && ebm_pkg::is_fetch(stat_reg);
    assign fq_pop  = EXEC_STROBE && TRACE_EXEC_MODE;

    ebm_fetch_queue #(.WIDTH(TW), .DEPTH(ebm_pkg::FIFO_DEPTH), .PW(ebm_pkg::PTR_W)) u_fq
    (
        .clk       (CLOCK),
        .rst       (RST),
        .push      (fq_push),
        .push_data ({addr_reg, BUS_DATA, stat_reg}),
        .pop       (fq_pop),
        .pop_data  (fq_out),
        .not_empty (fq_valid),
        .flush     (BREAK_REQ || !TRACE_EXEC_MODE)
    );

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            ANA_CLK  <= 1'b0;
            ANA_ADDR <= '0;
            ANA_DATA <= '0;
            ANA_STAT <= '0;
        end
        else
        begin
            ANA_CLK <= 1'b0;
            if (cycle_end && (!TRACE_EXEC_MODE || !ebm_pkg::is_fetch(stat_reg)))
            begin
                ANA_CLK  <= 1'b1;
                ANA_ADDR <= addr_reg;
                ANA_DATA <= BUS_DATA;
                ANA_STAT <= stat_reg;
            end
            else if (fq_pop && fq_valid)
            begin
                ANA_CLK  <= 1'b1;
                {ANA_ADDR, ANA_DATA, ANA_STAT} <= fq_out;
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/ebm_top_checker.sv */
// Checker: port assertions for the emulation bus mapper
`timescale 1ns/100ps
`default_nettype none
module ebm_top_checker
(
    // Clock and reset
    input wire logic                        CLOCK,
    input wire logic                        RST,
    // Watched ports
    input wire logic                        CFG_WR,
    input wire logic                        CPU_RESET_HELD,
    input wire logic                        CFG_ACCEPT,
    input wire logic                        USER_MEM_N,
    input wire logic                        EMEM_SEL,
    input wire logic                        TGT_BUF_EN,
    input wire logic                        EMEM_READY,
    input wire logic                        DMA_READY_ACK,
    input wire logic                        DMA_READY_ACK_OE,
    input wire logic                        ANA_CLK,
    input wire logic [ebm_pkg::ADDR_W-1:0]  ANA_ADDR,
    input wire logic                        BREAK_REQ,
    input wire logic                        IN_MONITOR,
    input wire logic                        HOST_STALL_REQ,
    input wire logic                        CPU_HALT,
    input wire logic [3:0]                  POD_STATUS,
    input wire logic                        TRACE_EXEC_MODE
);
    // ----------------------------------------
    // Halt length counter and assertions
    // ----------------------------------------
    logic [4:0] halt_cnt_reg;
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            halt_cnt_reg <= 5'h00;
        else if (CPU_HALT)
            halt_cnt_reg <= halt_cnt_reg + 5'h01;
        else
            halt_cnt_reg <= 5'h00;
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    cfg_accept_a: assert property (CFG_WR && CPU_RESET_HELD |=> CFG_ACCEPT)
        else $error("config write not accepted");
    cfg_refuse_a: assert property (CFG_ACCEPT |-> $past(CFG_WR && CPU_RESET_HELD))
        else $error("config accepted without held reset");
    user_mem_a: assert property (USER_MEM_N == EMEM_SEL)
        else $error("target access level disagrees with select");
    tgt_buf_a: assert property (TGT_BUF_EN |-> !USER_MEM_N)
        else $error("target buffers on in emulation cycle");
    dma_ack_a: assert property (DMA_READY_ACK_OE && !$past(RST)
        |-> DMA_READY_ACK == !$past(EMEM_READY))
        else $error("ready acknowledge wrong");
    ana_hold_a: assert property (!ANA_CLK |-> $stable(ANA_ADDR))
        else $error("trace address changed without clock");
    break_mon_a: assert property (BREAK_REQ |=> IN_MONITOR)
        else $error("break did not enter monitor");
    break_pulse_a: assert property (BREAK_REQ |=> !BREAK_REQ)
        else $error("break request longer than one cycle");
    break_quiet_a: assert property ($past(IN_MONITOR) |-> !BREAK_REQ)
        else $error("break raised inside monitor");
    stall_start_a: assert property ($rose(HOST_STALL_REQ) && !CPU_RESET_HELD && !CPU_HALT
        |-> ##[1:2] CPU_HALT)
        else $error("stall request not taken");
    halt_len_a: assert property ($fell(CPU_HALT) |-> halt_cnt_reg == 5'h0a)
        else $error("stall length wrong");
    pod_stat_a: assert property (!$past(RST) |-> POD_STATUS == {$past(CPU_RESET_HELD),
        $past(IN_MONITOR), $past(CPU_HALT), $past(TRACE_EXEC_MODE)})
        else $error("pod status wrong");
endmodule
bind ebm_top ebm_top_checker u_chk
(
    .CLOCK(CLOCK), .RST(RST), .CFG_WR(CFG_WR), .CPU_RESET_HELD(CPU_RESET_HELD),
    .CFG_ACCEPT(CFG_ACCEPT), .USER_MEM_N(USER_MEM_N), .EMEM_SEL(EMEM_SEL),
    .TGT_BUF_EN(TGT_BUF_EN), .EMEM_READY(EMEM_READY), .DMA_READY_ACK(DMA_READY_ACK),
    .DMA_READY_ACK_OE(DMA_READY_ACK_OE), .ANA_CLK(ANA_CLK), .ANA_ADDR(ANA_ADDR),
    .BREAK_REQ(BREAK_REQ), .IN_MONITOR(IN_MONITOR), .HOST_STALL_REQ(HOST_STALL_REQ),
    .CPU_HALT(CPU_HALT), .POD_STATUS(POD_STATUS), .TRACE_EXEC_MODE(TRACE_EXEC_MODE)
);
`default_nettype wire

/* File: bench/ebm_emem_model.sv */
// Partner: emulation memory ready responder and target memory gate
`timescale 1ns/100ps
`default_nettype none
module ebm_emem_model
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Memory side
    input wire logic        sel,
    input wire logic [1:0]  lat,
    output logic            ready,
    // Target side
    input wire logic        user_mem_n,
    output logic            tgt_mem_en
);
    logic [1:0] wait_reg;
    // Ready lat+1 cycles after select, dropped when deselected
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wait_reg <= 2'h0;
            ready <= 1'b0;
        end
        else if (!sel)
        begin
            wait_reg <= 2'h0;
            ready <= 1'b0;
        end
        else if (wait_reg == lat)
            ready <= 1'b1;
        else
            wait_reg <= wait_reg + 2'h1;
    end
    // Target memory off during emulation cycles
    assign tgt_mem_en = !user_mem_n;
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Testbench: scenarios for mapper, steering, break, stall and trace
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp); \
        end \
    end
module tb;
    logic CLOCK = 1'b0, RST = 1'b1, AS_N = 1'b1, RW = 1'b1, DMA_CYCLE = 1'b0;
    logic EXEC_STROBE = 1'b0, ROM_WR_BREAK_EN = 1'b0, MONITOR_EXIT = 1'b0, CFG_WR = 1'b0;
    logic CPU_RESET_HELD = 1'b1, HOST_STALL_REQ = 1'b0, TRACE_EXEC_MODE = 1'b0;
    logic [23:0] BUS_ADDR = 24'h000000, EMEM_ADDR, ANA_ADDR, ana_a;
    logic [15:0] BUS_DATA = 16'h0000, ANA_DATA, ana_d;
    logic [7:0]  BUS_STAT = 8'h00, ANA_STAT, ana_s;
    logic [5:0]  CFG_BLK = 6'h00;
    logic [2:0]  CFG_ATTR = 3'h0;
    logic [1:0]  emem_lat = 2'h0;
    logic [3:0]  POD_STATUS;
    logic EMEM_READY, EMEM_SEL, EMEM_BUF_EN, EMEM_BUF_DIR, USER_MEM_N, TGT_BUF_EN;
    logic TGT_BUF_DIR, DMA_READY_ACK, DMA_READY_ACK_OE, BREAK_REQ, IN_MONITOR;
    logic CFG_ACCEPT, CPU_HALT, ANA_CLK, tgt_mem_en;
    int fails = 0, total_checks = 0, ana_n = 0, brk_n = 0, acc_n = 0, tick_n = 0;
    ebm_top dut
    (
        .CLOCK(CLOCK), .RST(RST), .AS_N(AS_N), .RW(RW), .DMA_CYCLE(DMA_CYCLE),
        .EXEC_STROBE(EXEC_STROBE), .BUS_ADDR(BUS_ADDR), .BUS_DATA(BUS_DATA),
        .BUS_STAT(BUS_STAT), .EMEM_READY(EMEM_READY), .EMEM_ADDR(EMEM_ADDR),
        .EMEM_SEL(EMEM_SEL), .EMEM_BUF_EN(EMEM_BUF_EN), .EMEM_BUF_DIR(EMEM_BUF_DIR),
        .USER_MEM_N(USER_MEM_N), .TGT_BUF_EN(TGT_BUF_EN), .TGT_BUF_DIR(TGT_BUF_DIR),
        .DMA_READY_ACK(DMA_READY_ACK), .DMA_READY_ACK_OE(DMA_READY_ACK_OE),
        .ROM_WR_BREAK_EN(ROM_WR_BREAK_EN), .BREAK_REQ(BREAK_REQ), .IN_MONITOR(IN_MONITOR),
        .MONITOR_EXIT(MONITOR_EXIT), .CPU_RESET_HELD(CPU_RESET_HELD), .CFG_WR(CFG_WR),
        .CFG_BLK(CFG_BLK), .CFG_ATTR(CFG_ATTR), .CFG_ACCEPT(CFG_ACCEPT),
        .HOST_STALL_REQ(HOST_STALL_REQ), .CPU_HALT(CPU_HALT), .POD_STATUS(POD_STATUS),
        .TRACE_EXEC_MODE(TRACE_EXEC_MODE), .ANA_CLK(ANA_CLK), .ANA_ADDR(ANA_ADDR),
        .ANA_DATA(ANA_DATA), .ANA_STAT(ANA_STAT)
    );
    ebm_emem_model partner
    (
        .clk(CLOCK), .rst(RST), .sel(EMEM_SEL), .lat(emem_lat), .ready(EMEM_READY),
        .user_mem_n(USER_MEM_N), .tgt_mem_en(tgt_mem_en)
    );
    always #25 CLOCK = ~CLOCK;
    // Pulse counters and timeout
    always @(posedge CLOCK)
    begin
        tick_n++;
        if (ANA_CLK === 1'b1)
        begin
            ana_n++;
            ana_a = ANA_ADDR;
            ana_d = ANA_DATA;
            ana_s = ANA_STAT;
        end
        if (BREAK_REQ === 1'b1)
            brk_n++;
        if (CFG_ACCEPT === 1'b1)
            acc_n++;
        if (tick_n == 4000)
        begin
            fails++;
            results();
        end
    end
    task automatic results();
        if (fails == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cyc(input logic [23:0] a, input logic rw, input logic fetch,
                       input logic dma, input logic emul, input logic tgt);
        @(posedge CLOCK);
        AS_N <= 1'b0;
        BUS_ADDR <= a;
        BUS_DATA <= a[15:0] ^ 16'h5a5a;
        BUS_STAT <= {7'h00, fetch};
        RW <= rw;
        DMA_CYCLE <= dma;
        repeat (5) @(posedge CLOCK);
        #1;
        `CHK(EMEM_ADDR, a)
        `CHK(USER_MEM_N, emul)
        `CHK(EMEM_SEL, emul)
        `CHK(TGT_BUF_EN, tgt)
        `CHK(EMEM_BUF_EN, emul & ~dma)
        `CHK(DMA_READY_ACK_OE, emul & dma)
        `CHK(DMA_READY_ACK, ~(emul & EMEM_READY))
        `CHK(EMEM_BUF_DIR, rw)
        if (tgt)
            `CHK(TGT_BUF_DIR, rw)
        @(posedge CLOCK);
        AS_N <= 1'b1;
        repeat (4) @(posedge CLOCK);
        #1;
    endtask
    task automatic ana_is(input logic [23:0] a, input logic fetch);
        `CHK(ana_a, a)
        `CHK(ana_d, a[15:0] ^ 16'h5a5a)
        `CHK(ana_s, {7'h00, fetch})
    endtask
    task automatic pulse_exit();
        MONITOR_EXIT <= 1'b1;
        @(posedge CLOCK);
        MONITOR_EXIT <= 1'b0;
        repeat (2) @(posedge CLOCK);
        #1;
        `CHK(IN_MONITOR, 1'b0)
    endtask
    task automatic cfg(input logic [5:0] b, input logic [2:0] at, input logic held);
        CPU_RESET_HELD <= held;
        CFG_WR <= 1'b1;
        CFG_BLK <= b;
        CFG_ATTR <= at;
        @(posedge CLOCK);
        CFG_WR <= 1'b0;
        repeat (3) @(posedge CLOCK);
        #1;
    endtask
    task automatic t_cfg();
        cfg(6'h04, 3'h4, 1'b0);
        `CHK(acc_n, 0)
        cfg(6'h01, 3'h4, 1'b1);
        cfg(6'h02, 3'h0, 1'b1);
        cfg(6'h03, 3'h5, 1'b1);
        `CHK(acc_n, 3)
        CPU_RESET_HELD <= 1'b0;
    endtask
    task automatic t_bus();
        cyc(24'h040010, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        `CHK(ana_n, 1)
        ana_is(24'h040010, 1'b1);
        cyc(24'h080020, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        `CHK(ana_n, 2)
        ana_is(24'h080020, 1'b0);
    endtask
    task automatic t_break();
        cyc(24'h100000, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        `CHK(brk_n, 1)
        `CHK(IN_MONITOR, 1'b1)
        pulse_exit();
        cyc(24'h0c0004, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        `CHK(brk_n, 1)
        ROM_WR_BREAK_EN <= 1'b1;
        cyc(24'h0c0004, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        `CHK(brk_n, 2)
        pulse_exit();
        cyc(24'h0c0008, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        `CHK(brk_n, 2)
    endtask
    task automatic t_dma();
        cyc(24'h040100, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        `CHK(DMA_READY_ACK_OE, 1'b0)
        emem_lat <= 2'h3;
        cyc(24'h040104, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        cyc(24'h080100, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    endtask
    task automatic t_exec();
        int n;
        n = ana_n;
        TRACE_EXEC_MODE <= 1'b1;
        cyc(24'h040200, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        `CHK(ana_n, n)
        cyc(24'h040300, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        `CHK(ana_n, n + 1)
        ana_is(24'h040300, 1'b0);
        EXEC_STROBE <= 1'b1;
        @(posedge CLOCK);
        EXEC_STROBE <= 1'b0;
        repeat (3) @(posedge CLOCK);
        #1;
        `CHK(ana_n, n + 2)
        ana_is(24'h040200, 1'b1);
        TRACE_EXEC_MODE <= 1'b0;
        cyc(24'h040400, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        `CHK(ana_n, n + 3)
    endtask
    task automatic t_stall();
        int k;
        k = 0;
        HOST_STALL_REQ <= 1'b1;
        @(posedge CLOCK);
        HOST_STALL_REQ <= 1'b0;
        repeat (16)
        begin
            @(posedge CLOCK);
            #1;
            if (CPU_HALT === 1'b1)
                k++;
        end
        `CHK(k, ebm_pkg::STALL_CYCLES)
        `CHK(POD_STATUS, 4'h0)
    endtask
    initial
    begin
        repeat (2) @(posedge CLOCK);
        RST <= 1'b0;
        #1;
        `CHK(USER_MEM_N, 1'b0)
        t_cfg();
        t_bus();
        t_break();
        t_dma();
        t_exec();
        t_stall();
        results();
    end
endmodule
`default_nettype wire
